//--- vr_seq_regs.svh
// register offsets, field positions, reset values, vid codes and timing
// assumes inclusion by bare name from every file that needs a number
`ifndef VR_SEQ_REGS_SVH
`define VR_SEQ_REGS_SVH

// ahb register map, byte offsets within the decoded window
`define ADDR_DECODE_BITS  8
`define STATUS_OFFSET     8'h00
`define VID_SET_OFFSET    8'h04

// field positions inside the vid set word
`define VID_SET_CORE_LSB  0
`define VID_SET_AUX_LSB   8

// field positions inside the status word
`define STAT_STATE_LSB    0
`define STAT_MODE_BIT     4
`define STAT_VFIX_BIT     5
`define STAT_SUPPLY_BIT   6
`define STAT_QR_BIT       7
`define STAT_POWER_GOOD_OUTPUT_BIT    8
`define STAT_PHASE_LSB    10
`define STAT_BOOT_LSB     16
`define STAT_CORE_LSB     24

// serial vid codes, 12.5 mV per step below 1.55 V
`define BOOT_VID_00       7'h24
`define BOOT_VID_01       7'h2C
`define BOOT_VID_10       7'h34
`define BOOT_VID_11       7'h3C
`define FIX_VID_00        7'h0C
`define FIX_VID_01        7'h1C
`define FIX_VID_10        7'h2C
`define FIX_VID_11        7'h3C

// reset values
`define VID_RESET_CODE    7'h7F
`define PVID_NO_CODE      6'h3F
`define PHASES_DEFAULT    3'h4

// time between two vid steps while ramping, and its cycle count
`define CLK_PERIOD_NS     8
`define RAMP_STEP_NS      80
`define RAMP_STEP_CYCLES  ((`RAMP_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- vr_seq_pkg.sv
// types shared by the start-up sequencer and its self-checking bench
// assumes nothing beyond a systemverilog compiler
package vr_seq_pkg;

  // start-up sequence states
  typedef enum logic [2:0]
  {
    st_off       = 3'b000,
    st_idle      = 3'b001,
    st_pvi_wait  = 3'b010,
    st_pvi_ramp  = 3'b011,
    st_svi_boot  = 3'b100,
    st_svi_link  = 3'b101,
    st_svi_run   = 3'b110,
    st_vfix      = 3'b111
  } seq_state_type;

  // interface select latched at the enable edge
  typedef enum logic
  {
    serial_vid_mode   = 1'b0,
    parallel_vid_mode = 1'b1
  } vid_mode_type;

endpackage

//--- reg_link_if.sv
// carries register fields between the ahb slave and the sequencer
// assumes both ends run on the same hclk
`timescale 1ns/1ns
interface reg_link_if;
  logic        vid_write;
  logic [6:0]  core_vid_req;
  logic [6:0]  aux_vid_req;
  logic [31:0] status_word;

  modport bus
  (
    output vid_write,
    output core_vid_req,
    output aux_vid_req,
    input  status_word
  );

  modport core
  (
    input  vid_write,
    input  core_vid_req,
    input  aux_vid_req,
    output status_word
  );
endinterface

//--- pin_sync.sv
// three-stage pin synchroniser with agreement filter, one per bit
// assumes pins are asynchronous to hclk
`timescale 1ns/1ns
module pin_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_level
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : bit_sync
      logic stage1;
      logic stage2;
      logic stage3;
      logic next_level;

      // level moves only once stages two and three agree
      always_comb
      begin
        next_level = (stage2 == stage3) ? stage3 : pin_level[i];
      end

      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          stage1       <= 1'b0;
          stage2       <= 1'b0;
          stage3       <= 1'b0;
          pin_level[i] <= 1'b0;
        end
        else
        begin
          stage1       <= pin_in[i];
          stage2       <= stage1;
          stage3       <= stage2;
          pin_level[i] <= next_level;
        end
      end
    end
  endgenerate

endmodule

//--- ahb_reg_slave.sv
// ahb-lite slave for the sequencer registers, zero wait states
// assumes a single master and a decoder driving hsel
`timescale 1ns/1ns
`include "vr_seq_regs.svh"
module ahb_reg_slave
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  reg_link_if.bus          regs
);

  localparam logic [2:0] WORD_SIZE = 3'h2;

  logic                         wr_pending;
  logic [`ADDR_DECODE_BITS-1:0] wr_addr;
  logic                         next_wr_pending;
  logic [`ADDR_DECODE_BITS-1:0] next_wr_addr;
  logic [31:0]                  next_hrdata;
  logic                         next_vid_write;
  logic [6:0]                   next_core_req;
  logic [6:0]                   next_aux_req;
  logic                         accept;

  // unmapped offsets read as zero
  function automatic logic [31:0] read_word
  (
    input logic [`ADDR_DECODE_BITS-1:0] addr
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    if (addr == `STATUS_OFFSET)
      w = regs.status_word;
    else if (addr == `VID_SET_OFFSET)
    begin
      w[`VID_SET_CORE_LSB +: 7] = regs.core_vid_req;
      w[`VID_SET_AUX_LSB +: 7]  = regs.aux_vid_req;
    end
    return w;
  endfunction

  assign accept = hsel && hready && htrans[1];

  // address phase captured, write applied in its data phase
  always_comb
  begin
    next_wr_pending = accept && hwrite && (hsize == WORD_SIZE);
    next_wr_addr    = haddr[`ADDR_DECODE_BITS-1:0];
    next_hrdata     = hrdata;
    if (accept && !hwrite)
      next_hrdata = read_word(haddr[`ADDR_DECODE_BITS-1:0]);
    next_vid_write = 1'b0;
    next_core_req  = regs.core_vid_req;
    next_aux_req   = regs.aux_vid_req;
    if (wr_pending && wr_addr == `VID_SET_OFFSET)
    begin
      next_vid_write = 1'b1;
      next_core_req  = hwdata[`VID_SET_CORE_LSB +: 7];
      next_aux_req   = hwdata[`VID_SET_AUX_LSB +: 7];
    end
  end

  // hreadyout and hresp stay constant: no wait states, always okay
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pending        <= 1'b0;
      wr_addr           <= '0;
      hrdata            <= 32'h0000_0000;
      hreadyout         <= 1'b1;
      hresp             <= 1'b0;
      regs.vid_write    <= 1'b0;
      regs.core_vid_req <= `VID_RESET_CODE;
      regs.aux_vid_req  <= `VID_RESET_CODE;
    end
    else
    begin
      wr_pending        <= next_wr_pending;
      wr_addr           <= next_wr_addr;
      hrdata            <= next_hrdata;
      hreadyout         <= 1'b1;
      hresp             <= 1'b0;
      regs.vid_write    <= next_vid_write;
      regs.core_vid_req <= next_core_req;
      regs.aux_vid_req  <= next_aux_req;
    end
  end

endmodule

//--- vr_startup_mode_sequencer.sv
// start-up, mode select and gate forcing for a multiphase vr controller
// assumes analog comparators deliver the supply, sense, window and
// feedback-drop decisions as digital levels asynchronous to hclk
//
// The implementer's own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ns
`include "vr_seq_regs.svh"

// Behaviour
// - before power ok, regulate to boot vid
// - power good low while outside window
// - fixed-vid pin forces debug serial mode
// - debug mode follows clock/data code live
// - debug codes give 1.4/1.2/1.0/0.8 V
// - boot codes give 1.1/1.0/0.9/0.8 V
// - supply ready needs both supplies good
// - supply not ready turns all gates off
// - enable rising edge latches interface mode
// - select high parallel, low serial
// - parallel mode: aux rail hiz, ignore power-ok
// - parallel: wait valid code, then ramp
// - serial: capture clock/data as boot vid
// - default four phases, sense pins reduce
// - sense high means above 5V supply minus 1V
// - phase count latched at supply ready
// - quick response: high sides on, lows off
module vr_startup_mode_sequencer
  import vr_seq_pkg::*;
#(
  parameter int PHASES    = 4,
  parameter int RAMP_STEP = `RAMP_STEP_CYCLES
)
(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic [31:0]            hrdata,
  output logic                   hresp,
  input  wire logic              supply_12v_monitor,
  input  wire logic              supply_5v_monitor,
  input  wire logic              enable,
  input  wire logic              interface_select_pin,
  input  wire logic              fixed_vid_enable_pin,
  input  wire logic              serial_vid_clock,
  input  wire logic              serial_vid_data,
  input  wire logic              power_ok_input,
  input  wire logic [5:0]        parallel_vid,
  input  wire logic              phase_four_sense,
  input  wire logic              phase_three_sense,
  input  wire logic              phase_two_sense,
  input  wire logic              feedback_drop,
  input  wire logic              core_in_window,
  input  wire logic [PHASES-1:0] pwm_request,
  output logic                   power_good_output,
  output logic [6:0]             core_rail_vid,
  output logic [6:0]             auxiliary_rail_vid,
  output logic                   auxiliary_rail_hiz,
  output logic                   core_rail_enable,
  output logic [PHASES-1:0]      high_side_gate,
  output logic [PHASES-1:0]      low_side_gate,
  output logic [2:0]             phase_count,
  output logic                   quick_response_flag
);

  localparam int SYNC_W = 19;

  reg_link_if regs ();

  logic [SYNC_W-1:0] pins;
  logic              s_12v;
  logic              s_5v;
  logic              s_enable;
  logic              s_ifsel;
  logic              s_vfix;
  logic              s_clock;
  logic              s_data;
  logic              s_power_ok_input;
  logic [5:0]        s_pvid;
  logic              s_ph4;
  logic              s_ph3;
  logic              s_ph2;
  logic              s_drop;
  logic              s_window;

  seq_state_type state;
  seq_state_type next_state;
  vid_mode_type  mode;
  vid_mode_type  next_mode;
  logic          supply_ready;
  logic          next_supply_ready;
  logic          enable_prev;
  logic [6:0]    boot_vid;
  logic [6:0]    next_boot_vid;
  logic [6:0]    core_target;
  logic [6:0]    next_core_target;
  logic [6:0]    aux_target;
  logic [6:0]    next_aux_target;
  logic [2:0]    next_phase_count;
  logic [15:0]   ramp_count;
  logic [15:0]   next_ramp_count;
  logic [6:0]    next_core_vid;
  logic [6:0]    next_aux_vid;
  logic          running;
  logic          next_power_good_output;
  logic          next_qr;
  logic          next_core_en;
  logic          next_aux_hiz;
  logic [PHASES-1:0] mask;
  logic [PHASES-1:0] next_high;
  logic [PHASES-1:0] next_low;

  // every pin except pwm_request and the bus through three stages with agreement filter
  pin_sync #(.WIDTH(SYNC_W)) sync_pins
  (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .pin_in    ({supply_12v_monitor, supply_5v_monitor, enable,
                 interface_select_pin, fixed_vid_enable_pin,
                 serial_vid_clock, serial_vid_data, power_ok_input,
                 parallel_vid, phase_four_sense, phase_three_sense,
                 phase_two_sense, feedback_drop, core_in_window}),
    .pin_level (pins)
  );

  assign {s_12v, s_5v, s_enable, s_ifsel, s_vfix, s_clock, s_data,
          s_power_ok_input, s_pvid, s_ph4, s_ph3, s_ph2, s_drop, s_window} = pins;

  ahb_reg_slave bus_slave
  (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp),
    .regs      (regs.bus)
  );

  // boot table, clock is the upper bit
  function automatic logic [6:0] boot_code(input logic [1:0] c);
    unique case (c)
      2'b00: return `BOOT_VID_00;
      2'b01: return `BOOT_VID_01;
      2'b10: return `BOOT_VID_10;
      2'b11: return `BOOT_VID_11;
    endcase
  endfunction

  // debug fixed-voltage table, clock is the upper bit
  function automatic logic [6:0] fix_code(input logic [1:0] c);
    unique case (c)
      2'b00: return `FIX_VID_00;
      2'b01: return `FIX_VID_01;
      2'b10: return `FIX_VID_10;
      2'b11: return `FIX_VID_11;
    endcase
  endfunction

  // one code step toward the target; lower code means higher volts
  function automatic logic [6:0] step_to
  (
    input logic [6:0] cur,
    input logic [6:0] tgt
  );
    if (cur < tgt)
      return cur + 7'h01;
    else if (cur > tgt)
      return cur - 7'h01;
    return cur;
  endfunction

  // status word for the register slave
  always_comb
  begin
    regs.status_word = 32'h0000_0000;
    regs.status_word[`STAT_STATE_LSB +: 3] = state;
    regs.status_word[`STAT_MODE_BIT]       = mode;
    regs.status_word[`STAT_VFIX_BIT]       = (state == st_vfix);
    regs.status_word[`STAT_SUPPLY_BIT]     = supply_ready;
    regs.status_word[`STAT_QR_BIT]         = quick_response_flag;
    regs.status_word[`STAT_POWER_GOOD_OUTPUT_BIT]      = power_good_output;
    regs.status_word[`STAT_PHASE_LSB +: 3] = phase_count;
    regs.status_word[`STAT_BOOT_LSB +: 7]  = boot_vid;
    regs.status_word[`STAT_CORE_LSB +: 7]  = core_rail_vid;
  end

  // sequence: supply, mode latch, per-mode start-up steps
  always_comb
  begin
    next_supply_ready = s_12v && s_5v;
    next_state        = state;
    next_mode         = mode;
    next_boot_vid     = boot_vid;
    next_core_target  = core_target;
    next_aux_target   = aux_target;
    next_phase_count  = phase_count;
    // sense pins read only on the supply-ready rising edge
    if (next_supply_ready && !supply_ready)
    begin
      next_phase_count = `PHASES_DEFAULT;
      if (s_ph2)
        next_phase_count = 3'h1;
      else if (s_ph3)
        next_phase_count = 3'h2;
      else if (s_ph4)
        next_phase_count = 3'h3;
    end
    if (!next_supply_ready)
      next_state = st_off;
    else if (s_vfix)
    begin
      next_state       = st_vfix;
      next_core_target = fix_code({s_clock, s_data});
      next_aux_target  = fix_code({s_clock, s_data});
    end
    else
    begin
      unique case (state)
        st_off:
          next_state = st_idle;
        st_idle, st_vfix:
          if (s_enable && (!enable_prev || state == st_vfix))
          begin
            next_mode = s_ifsel ? parallel_vid_mode
                                : serial_vid_mode;
            if (s_ifsel)
              next_state = st_pvi_wait;
            else
            begin
              next_state       = st_svi_boot;
              next_boot_vid    = boot_code({s_clock, s_data});
              next_core_target = boot_code({s_clock, s_data});
              next_aux_target  = boot_code({s_clock, s_data});
            end
          end
          else
            next_state = st_idle;
        st_pvi_wait, st_pvi_ramp:
          if (s_pvid != `PVID_NO_CODE)
          begin
            next_state       = st_pvi_ramp;
            next_core_target = {1'b0, s_pvid};
          end
        st_svi_boot:
          begin
            next_core_target = boot_vid;
            next_aux_target  = boot_vid;
            if (s_power_ok_input)
              next_state = st_svi_link;
          end
        st_svi_link, st_svi_run:
          if (!s_power_ok_input)
            next_state = st_svi_boot;
          else if (regs.vid_write)
          begin
            next_state       = st_svi_run;
            next_core_target = regs.core_vid_req;
            next_aux_target  = regs.aux_vid_req;
          end
      endcase
      // enable low drops back to wait for the next edge
      if (!s_enable && next_state != st_idle)
        next_state = st_idle;
    end
  end

  // rail outputs ramp one code per step period
  always_comb
  begin
    running = (state != st_off) && (state != st_idle)
              && (state != st_pvi_wait);
    next_ramp_count = ramp_count + 16'h0001;
    next_core_vid   = core_rail_vid;
    next_aux_vid    = auxiliary_rail_vid;
    if (!running)
    begin
      next_ramp_count = 16'h0000;
      next_core_vid   = core_target;
      next_aux_vid    = aux_target;
    end
    else if (ramp_count >= 16'(RAMP_STEP - 1))
    begin
      next_ramp_count = 16'h0000;
      next_core_vid   = step_to(core_rail_vid, core_target);
      next_aux_vid    = step_to(auxiliary_rail_vid, aux_target);
    end
    next_core_en = running;
    next_aux_hiz = !running || (mode == parallel_vid_mode
                                && state != st_vfix);
    next_power_good_output   = next_supply_ready && running && s_window
                   && (core_rail_vid == core_target);
  end

  // gate forcing: supply loss first, then quick response, then pwm
  always_comb
  begin
    mask = '0;
    for (int p = 0; p < PHASES; p++)
      mask[p] = (3'(p) < phase_count);
    next_qr   = s_drop;
    next_high = pwm_request & mask;
    next_low  = ~pwm_request & mask;
    if (!running)
    begin
      next_high = '0;
      next_low  = '0;
    end
    if (next_qr)
    begin
      next_high = mask;
      next_low  = '0;
    end
    if (!next_supply_ready)
    begin
      next_high = '0;
      next_low  = '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state               <= st_off;
      mode                <= serial_vid_mode;
      supply_ready        <= 1'b0;
      enable_prev         <= 1'b0;
      boot_vid            <= `VID_RESET_CODE;
      core_target         <= `VID_RESET_CODE;
      aux_target          <= `VID_RESET_CODE;
      phase_count         <= `PHASES_DEFAULT;
      ramp_count          <= 16'h0000;
      core_rail_vid       <= `VID_RESET_CODE;
      auxiliary_rail_vid  <= `VID_RESET_CODE;
      core_rail_enable    <= 1'b0;
      auxiliary_rail_hiz  <= 1'b1;
      power_good_output   <= 1'b0;
      quick_response_flag <= 1'b0;
      high_side_gate      <= '0;
      low_side_gate       <= '0;
    end
    else
    begin
      state               <= next_state;
      mode                <= next_mode;
      supply_ready        <= next_supply_ready;
      enable_prev         <= s_enable;
      boot_vid            <= next_boot_vid;
      core_target         <= next_core_target;
      aux_target          <= next_aux_target;
      phase_count         <= next_phase_count;
      ramp_count          <= next_ramp_count;
      core_rail_vid       <= next_core_vid;
      auxiliary_rail_vid  <= next_aux_vid;
      core_rail_enable    <= next_core_en;
      auxiliary_rail_hiz  <= next_aux_hiz;
      power_good_output   <= next_power_good_output;
      quick_response_flag <= next_qr;
      high_side_gate      <= next_high;
      low_side_gate       <= next_low;
    end
  end

endmodule

//--- vr_seq_assertions.sv
// checker for sequencer outputs against their pin causes
// assumes a bind onto the top module, one hclk domain
`timescale 1ns/1ns
module vr_seq_checker
#(
  parameter int PHASES = 4
)
(
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              hreadyout,
  input wire logic              hresp,
  input wire logic              supply_12v_monitor,
  input wire logic              supply_5v_monitor,
  input wire logic              feedback_drop,
  input wire logic              core_in_window,
  input wire logic              power_good_output,
  input wire logic [PHASES-1:0] high_side_gate,
  input wire logic [PHASES-1:0] low_side_gate,
  input wire logic [2:0]        phase_count,
  input wire logic              quick_response_flag
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // repeat counts cover four sync stages plus the output register
  chk_gates_off_12v: assert property (
    !supply_12v_monitor [*6] |-> high_side_gate == '0 && low_side_gate == '0)
    else $error("gates driven with 12v supply low");
  chk_gates_off_5v: assert property (
    $fell(supply_5v_monitor) |-> ##[1:5] high_side_gate == '0)
    else $error("high sides still on after 5v supply fell");
  chk_qr_raise: assert property (
    feedback_drop [*6] |-> quick_response_flag)
    else $error("quick response flag missing on feedback drop");
  chk_qr_gates: assert property (
    (feedback_drop && supply_12v_monitor && supply_5v_monitor) [*7]
    |-> high_side_gate[0] && low_side_gate == '0)
    else $error("quick response did not force gates");
  chk_power_good_output_window: assert property (
    !core_in_window [*7] |-> !power_good_output)
    else $error("power good high outside window");
  chk_phase_range: assert property (
    phase_count >= 3'h1 && phase_count <= 3'h4)
    else $error("phase count out of range");
  chk_phase_hold: assert property (
    (supply_12v_monitor && supply_5v_monitor) [*8] |-> $stable(phase_count))
    else $error("phase count changed after start-up");
  chk_bus_okay: assert property (
    hreadyout && !hresp)
    else $error("slave stalled or answered with error");
endmodule

bind vr_startup_mode_sequencer vr_seq_checker #(.PHASES(PHASES)) chk
(
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .supply_12v_monitor(supply_12v_monitor),
  .supply_5v_monitor(supply_5v_monitor), .feedback_drop(feedback_drop),
  .core_in_window(core_in_window), .power_good_output(power_good_output),
  .high_side_gate(high_side_gate), .low_side_gate(low_side_gate),
  .phase_count(phase_count), .quick_response_flag(quick_response_flag)
);

//--- host_cpu_model.sv
// host processor model: boot or debug code pins and power ok
// assumes the bench chooses the code and permits power ok
`timescale 1ns/1ns
module host_cpu_model
#(
  parameter int LAG = 3
)
(
  input  wire logic       hclk,
  input  wire logic [1:0] code,
  input  wire logic       go,
  input  wire logic       power_good_output,
  output logic            serial_vid_clock,
  output logic            serial_vid_data,
  output logic            power_ok_input
);
  int wait_count = 0;
  initial {serial_vid_clock, serial_vid_data, power_ok_input} = 3'h0;
  // power ok once boot voltage was good a while, held while go
  always @(posedge hclk)
  begin
    {serial_vid_clock, serial_vid_data} <= code;
    wait_count <= go ? wait_count + power_good_output : 0;
    power_ok_input <= go && wait_count >= LAG;
  end
endmodule

//--- vr_startup_mode_sequencer_test.sv
// self-checking bench for the start-up and mode sequencer
// assumes the host model on the code pins
`timescale 1ns/1ns
`include "vr_seq_regs.svh"
module vr_startup_mode_sequencer_test
  import vr_seq_pkg::*;
;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, enable = 0;
  logic supply_12v_monitor = 0, supply_5v_monitor = 0, feedback_drop = 0;
  logic interface_select_pin = 0, fixed_vid_enable_pin = 0, host_go = 0;
  logic phase_four_sense = 0, phase_three_sense = 0, phase_two_sense = 0;
  logic core_in_window = 0;
  logic [1:0]  htrans = 2'h0, host_code = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [5:0]  parallel_vid = 6'h3F;
  logic [3:0]  pwm_request = 4'h0;
  wire  logic  hreadyout, hresp, power_good_output, auxiliary_rail_hiz;
  wire  logic  core_rail_enable, quick_response_flag, power_ok_input;
  wire  logic  serial_vid_clock, serial_vid_data;
  wire  logic [31:0] hrdata;
  wire  logic [6:0]  core_rail_vid, auxiliary_rail_vid;
  wire  logic [3:0]  high_side_gate, low_side_gate;
  wire  logic [2:0]  phase_count;
  int miscompares = 0, check_count = 0, cycles = 0, seed = 32'hb0ed78ac;
  int boot_q[$] = '{`BOOT_VID_00, `BOOT_VID_01, `BOOT_VID_10, `BOOT_VID_11};
  int fix_q[$] = '{`FIX_VID_00, `FIX_VID_01, `FIX_VID_10, `FIX_VID_11};

  vr_startup_mode_sequencer #(.PHASES(4), .RAMP_STEP(1)) dut
  (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .supply_12v_monitor,
    .supply_5v_monitor, .enable, .interface_select_pin, .feedback_drop,
    .fixed_vid_enable_pin, .serial_vid_clock, .serial_vid_data,
    .power_ok_input, .parallel_vid, .phase_four_sense, .phase_three_sense,
    .phase_two_sense, .core_in_window, .pwm_request, .power_good_output,
    .core_rail_vid, .auxiliary_rail_vid, .auxiliary_rail_hiz,
    .core_rail_enable, .high_side_gate, .low_side_gate, .phase_count,
    .quick_response_flag
  );
  host_cpu_model #(.LAG(3)) host
  (
    .hclk, .code(host_code), .go(host_go), .power_good_output,
    .serial_vid_clock, .serial_vid_data, .power_ok_input
  );

  initial forever #4 hclk = ~hclk;
  // random pwm and a cycle ceiling against hangs
  always @(posedge hclk)
  begin
    pwm_request <= 4'($random(seed));
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      close_out();
    end
  end

  task close_out();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // single word transfer, waits on hready
  task ahb(input logic [31:0] a, input logic w, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // poll with a bound; ramp length varies
  task wait_vid(input string nm, input logic [6:0] e);
    for (int n = 0; n < 400 && core_rail_vid !== e; n++)
      @(posedge hclk);
    check(nm, {25'h0, e}, {25'h0, core_rail_vid});
  endtask

  task power(input logic on);
    supply_12v_monitor <= on;
    supply_5v_monitor <= on;
    cyc(10);
  endtask

  initial
  begin
    cyc(2);
    hresetn <= 1'b1;
    cyc(1);
    check("reset vid", `VID_RESET_CODE, core_rail_vid);
    // one sense pin per start-up, none on the last for the default four
    for (int i = 3; i >= 0; i--)
    begin
      power(1'b0);
      phase_two_sense <= (i == 3);
      phase_three_sense <= (i == 2);
      phase_four_sense <= (i == 1);
      cyc(6);
      check("gates off", 0, {high_side_gate, low_side_gate});
      power(1'b1);
      check("phases", 4 - i, phase_count);
    end
    phase_two_sense <= 1'b1;
    cyc(10);
    check("phases held", 4, phase_count);
    // serial boot: each code captured at the enable rise
    for (int c = 0; c < 4; c++)
    begin
      enable <= 1'b0;
      host_code <= c[1:0];
      cyc(10);
      enable <= 1'b1;
      wait_vid("boot core", boot_q[c]);
      cyc(2);
      check("boot aux", boot_q[c], auxiliary_rail_vid);
      check("power_good_output outside", 0, power_good_output);
    end
    core_in_window <= 1'b1;
    host_go <= 1'b1;
    cyc(20);
    check("power_good_output", 1, power_good_output);
    check("power ok", 1, power_ok_input);
    ahb(`VID_SET_OFFSET, 1'b1, 32'h0000_4030);
    wait_vid("link core", 7'h30);
    ahb(`STATUS_OFFSET, 1'b0, 32'h0);
    check("status core", 32'h30, rd[30:24]);
    check("status mode", serial_vid_mode, rd[4]);
    ahb(32'h0000_0010, 1'b0, 32'h0);
    check("unmapped", 0, rd);
    // parallel waits; core holds its last serial target
    enable <= 1'b0;
    host_go <= 1'b0;
    interface_select_pin <= 1'b1;
    cyc(10);
    enable <= 1'b1;
    cyc(30);
    check("pvi hiz", 1, auxiliary_rail_hiz);
    check("pvi wait", 32'h30, core_rail_vid);
    check("pvi off", 0, core_rail_enable);
    host_go <= 1'b1;
    parallel_vid <= 6'h15;
    wait_vid("pvi core", 7'h15);
    cyc(20);
    check("pvi ignores ok", 7'h15, core_rail_vid);
    ahb(`STATUS_OFFSET, 1'b0, 32'h0);
    check("status mode", parallel_vid_mode, rd[4]);
    // debug mode tracks live code changes
    fixed_vid_enable_pin <= 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      host_code <= c[1:0];
      wait_vid("vfix core", fix_q[c]);
      repeat (60) if (auxiliary_rail_vid !== fix_q[c]) cyc(1);
      check("vfix aux", fix_q[c], auxiliary_rail_vid);
    end
    fixed_vid_enable_pin <= 1'b0;
    feedback_drop <= 1'b1;
    cyc(10);
    check("qr flag", 1, quick_response_flag);
    check("qr lows", 0, low_side_gate);
    check("qr highs", 4'hF, high_side_gate);
    supply_12v_monitor <= 1'b0;
    cyc(8);
    check("supply beats qr", 0, high_side_gate);
    close_out();
  end
endmodule
